// *** rtl/fpmc_top.v ***
// Front-panel mode controller with AHB-Lite register slave
//
// Implementation choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/100ps
`include "fpmc_defs.vh"
module fpmc_top
#(
	parameter [31:0] LONG_PRESS_CYC = `FPMC_LONG_PRESS_CYC,
	parameter [31:0] SHOW_NUM_CYC   = `FPMC_SHOW_NUM_CYC,
	parameter [35:0] IDLE_TO_CYC    = `FPMC_IDLE_TO_CYC,
	parameter [31:0] BEEP_CYC       = `FPMC_BEEP_CYC,
	parameter [31:0] FLASH_CYC      = `FPMC_FLASH_CYC,
	parameter [31:0] DEBOUNCE_CYC   = `FPMC_DEBOUNCE_CYC
)
(
	input  wire        ref_clk,
	input  wire        reset,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	input  wire        diagButton,
	input  wire        setButton1,
	input  wire        setButton2,
	input  wire [7:0]  oxygen,
	input  wire [7:0]  potValue1,
	input  wire [7:0]  potValue2,
	input  wire [7:0]  diagValue1,
	input  wire [7:0]  diagValue2,
	input  wire [7:0]  diagValue3,
	input  wire [7:0]  diagValue4,
	input  wire [7:0]  diagValue5,
	input  wire        compUp,
	input  wire        compDown,
	output reg  [2:0]  dispKind_q,
	output reg  [7:0]  dispValue_q,
	output reg         beep_q,
	output reg         alarmLed1_q,
	output reg         alarmLed2_q,
	output reg         alarm1_q,
	output reg         alarm2_q,
	output reg         outOfCal_q,
	output reg  [2:0]  baudSel_q,
	output reg         inNormal_q
);
	localparam [1:0] ST_NORMAL = 2'h0;
	localparam [1:0] ST_DIAG   = 2'h1;
	localparam [1:0] ST_SET1   = 2'h2;
	localparam [1:0] ST_SET2   = 2'h3;

	wire       diagLvl;
	wire       diagPress;
	wire       set1Press;
	wire       set2Press;
	wire [7:0] sp1;
	wire [7:0] sp2;
	wire       trip1;
	wire       trip2;

	reg [1:0]  state_q;
	reg [2:0]  seq_q;
	reg [31:0] holdCnt_q;
	reg        holdDone_q;
	reg [31:0] showCnt_q;
	reg [35:0] idleCnt_q;
	reg [31:0] beepCnt_q;
	reg [31:0] flashCnt_q;
	reg        flash_q;
	reg [7:0]  comp_q;
	reg [1:0]  ctrl_q;
	reg        remWr1_q;
	reg        remWr2_q;
	reg [7:0]  remVal_q;
	reg        leave1_q;
	reg        leave2_q;
	reg        apValid_q;
	reg        apWrite_q;
	reg [3:0]  apIdx_q;
	reg [7:0]  seqValue;
	wire       anySet;
	wire       serialOpt;

	assign anySet    = set1Press | set2Press;
	assign serialOpt = ctrl_q[`FPMC_CTRL_SERIAL];

	fpmc_debounce #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) uDbDiag (.ref_clk(ref_clk), .reset(reset),
		.rawIn(diagButton), .level_q(diagLvl), .press_q(diagPress));
	fpmc_debounce #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) uDbSet1 (.ref_clk(ref_clk), .reset(reset),
		.rawIn(setButton1), .level_q(), .press_q(set1Press));
	fpmc_debounce #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) uDbSet2 (.ref_clk(ref_clk), .reset(reset),
		.rawIn(setButton2), .level_q(), .press_q(set2Press));

	fpmc_alarm #(.TRIP_ABOVE(0), .ADJUSTABLE(1), .FIXED_SP(8'h32)) uAlarm1
	(
		.ref_clk     (ref_clk),
		.reset       (reset),
		.oxygen      (oxygen),
		.potValue    (potValue1),
		.tracking    (state_q == ST_SET1),
		.leaveSet    (leave1_q),
		.localLock   (ctrl_q[`FPMC_CTRL_LOCKOUT]),
		.remoteWr    (remWr1_q),
		.remoteValue (remVal_q),
		.activeSp_q  (sp1),
		.alarm_q     (trip1)
	);
	fpmc_alarm #(.TRIP_ABOVE(0), .ADJUSTABLE(1), .FIXED_SP(8'h28)) uAlarm2
	(
		.ref_clk     (ref_clk),
		.reset       (reset),
		.oxygen      (oxygen),
		.potValue    (potValue2),
		.tracking    (state_q == ST_SET2),
		.leaveSet    (leave2_q),
		.localLock   (ctrl_q[`FPMC_CTRL_LOCKOUT]),
		.remoteWr    (remWr2_q),
		.remoteValue (remVal_q),
		.activeSp_q  (sp2),
		.alarm_q     (trip2)
	);

	// Value of the current diagnostic sequence
	always @*
	begin
		seqValue = 8'h0;
		case (seq_q)
			3'h1: seqValue = diagValue1;
			3'h2: seqValue = diagValue2;
			3'h3: seqValue = diagValue3;
			3'h4: seqValue = diagValue4;
			3'h5: seqValue = diagValue5;
			3'h6: seqValue = comp_q;
			3'h7: seqValue = {5'h0, baudSel_q};
			default: seqValue = 8'h0;
		endcase
	end

	// Mode state machine
	always @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			state_q    <= ST_NORMAL;
			seq_q      <= 3'h1;
			holdCnt_q  <= 32'h0;
			holdDone_q <= 1'b0;
			showCnt_q  <= 32'h0;
			idleCnt_q  <= 36'h0;
			beepCnt_q  <= 32'h0;
			baudSel_q  <= `FPMC_BAUD_RST;
			leave1_q   <= 1'b0;
			leave2_q   <= 1'b0;
		end
		else
		begin
			leave1_q <= 1'b0;
			leave2_q <= 1'b0;
			if (beepCnt_q != 32'h0)
				beepCnt_q <= beepCnt_q - 32'h1;
			if (showCnt_q != 32'h0)
				showCnt_q <= showCnt_q - 32'h1;
			if (!diagLvl)
			begin
				holdCnt_q  <= 32'h0;
				holdDone_q <= 1'b0;
			end
			else if (!holdDone_q)
				holdCnt_q <= holdCnt_q + 32'h1;
			case (state_q)
				ST_NORMAL:
				begin
					if (diagLvl && !holdDone_q && holdCnt_q == LONG_PRESS_CYC - 1)
					begin
						holdDone_q <= 1'b1;
						state_q    <= ST_DIAG;
						beepCnt_q  <= BEEP_CYC;
						seq_q      <= 3'h1;
						showCnt_q  <= SHOW_NUM_CYC;
						idleCnt_q  <= 36'h0;
					end
					else if (set1Press)
						state_q <= ST_SET1;
					else if (set2Press)
						state_q <= ST_SET2;
				end
				ST_DIAG:
				begin
					if (diagPress || anySet)
						idleCnt_q <= 36'h0;
					else if (seq_q != 3'h6)
						idleCnt_q <= idleCnt_q + 36'h1;
					if (diagPress && holdDone_q)
						;
					else if (diagPress)
					begin
						showCnt_q <= SHOW_NUM_CYC;
						if (seq_q == 3'h7 || (seq_q == 3'h6 && !serialOpt))
							seq_q <= 3'h1;
						else
							seq_q <= seq_q + 3'h1;
					end
					else if (anySet && seq_q == 3'h7 && serialOpt)
					begin
						if (set1Press && baudSel_q != `FPMC_BAUD_MAX)
							baudSel_q <= baudSel_q + 3'h1;
						else if (set2Press && baudSel_q != 3'h0)
							baudSel_q <= baudSel_q - 3'h1;
					end
					else if (anySet)
						state_q <= ST_NORMAL;
					else if (seq_q != 3'h6 && idleCnt_q >= IDLE_TO_CYC - 36'h1)
						state_q <= ST_NORMAL;
				end
				ST_SET1, ST_SET2:
				begin
					if (diagPress)
					begin
						state_q  <= ST_NORMAL;
						leave1_q <= state_q == ST_SET1;
						leave2_q <= state_q == ST_SET2;
					end
					else if (set1Press)
						state_q <= ST_SET1;
					else if (set2Press)
						state_q <= ST_SET2;
				end
				default: state_q <= ST_NORMAL;
			endcase
		end
	end

	// Compensation factor and drift alarm
	always @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			comp_q     <= `FPMC_COMP_NOM;
			outOfCal_q <= 1'b0;
		end
		else if (compUp)
		begin
			if (comp_q == `FPMC_COMP_MAX)
				outOfCal_q <= 1'b1;
			else
				comp_q <= comp_q + 8'h1;
		end
		else if (compDown)
		begin
			if (comp_q == `FPMC_COMP_MIN)
				outOfCal_q <= 1'b1;
			else
				comp_q <= comp_q - 8'h1;
		end
	end

	// Display, lights and outputs
	always @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			flashCnt_q  <= 32'h0;
			flash_q     <= 1'b0;
			dispKind_q  <= `FPMC_DISP_NORMAL;
			dispValue_q <= 8'h0;
			beep_q      <= 1'b0;
			alarmLed1_q <= 1'b0;
			alarmLed2_q <= 1'b0;
			alarm1_q    <= 1'b0;
			alarm2_q    <= 1'b0;
			inNormal_q  <= 1'b1;
		end
		else
		begin
			if (flashCnt_q >= FLASH_CYC - 1)
			begin
				flashCnt_q <= 32'h0;
				flash_q    <= ~flash_q;
			end
			else
				flashCnt_q <= flashCnt_q + 32'h1;
			beep_q     <= beepCnt_q != 32'h0;
			alarm1_q   <= trip1;
			alarm2_q   <= trip2;
			inNormal_q <= state_q == ST_NORMAL;
			alarmLed1_q <= (state_q == ST_SET1) ? flash_q : trip1;
			alarmLed2_q <= (state_q == ST_SET2) ? flash_q : trip2;
			case (state_q)
				ST_DIAG:
				begin
					if (showCnt_q != 32'h0)
					begin
						dispKind_q  <= `FPMC_DISP_SEQNUM;
						dispValue_q <= {5'h0, seq_q};
					end
					else
					begin
						dispKind_q  <= (seq_q == 3'h7) ? `FPMC_DISP_BAUD : `FPMC_DISP_VALUE;
						dispValue_q <= seqValue;
					end
				end
				ST_SET1:
				begin
					dispKind_q  <= `FPMC_DISP_SETPT;
					dispValue_q <= ctrl_q[`FPMC_CTRL_LOCKOUT] ? sp1 : potValue1;
				end
				ST_SET2:
				begin
					dispKind_q  <= `FPMC_DISP_SETPT;
					dispValue_q <= ctrl_q[`FPMC_CTRL_LOCKOUT] ? sp2 : potValue2;
				end
				default:
				begin
					dispKind_q  <= `FPMC_DISP_NORMAL;
					dispValue_q <= oxygen;
				end
			endcase
		end
	end

	// AHB-Lite slave, zero wait states
	always @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			apValid_q <= 1'b0;
			apWrite_q <= 1'b0;
			apIdx_q   <= 4'h0;
			hrdata    <= 32'h0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			ctrl_q    <= `FPMC_CTRL_RST;
			remWr1_q  <= 1'b0;
			remWr2_q  <= 1'b0;
			remVal_q  <= 8'h0;
		end
		else
		begin
			remWr1_q  <= 1'b0;
			remWr2_q  <= 1'b0;
			apValid_q <= hsel && hready && htrans[1];
			apWrite_q <= hwrite;
			apIdx_q   <= haddr[5:2];
			if (hsel && hready && htrans[1] && !hwrite)
			begin
				case (haddr[5:2])
					`FPMC_ADDR_CTRL:   hrdata <= {30'h0, ctrl_q};
					`FPMC_ADDR_STATUS: hrdata <= {8'h0, comp_q, 5'h0, seq_q, 3'h0,
						outOfCal_q, trip2, trip1, state_q};
					`FPMC_ADDR_SP1:    hrdata <= {24'h0, sp1};
					`FPMC_ADDR_SP2:    hrdata <= {24'h0, sp2};
					`FPMC_ADDR_MEAS:   hrdata <= {21'h0, baudSel_q, oxygen};
					default:           hrdata <= 32'h0;
				endcase
			end
			if (apValid_q && apWrite_q)
			begin
				case (apIdx_q)
					`FPMC_ADDR_CTRL: ctrl_q <= hwdata[1:0];
					`FPMC_ADDR_SP1:
					begin
						remWr1_q <= 1'b1;
						remVal_q <= hwdata[7:0];
					end
					`FPMC_ADDR_SP2:
					begin
						remWr2_q <= 1'b1;
						remVal_q <= hwdata[7:0];
					end
					default: ;
				endcase
			end
		end
	end
endmodule

// *** rtl/fpmc_defs.vh ***
// Constants of the front-panel mode controller
`ifndef FPMC_DEFS_VH
`define FPMC_DEFS_VH
`define FPMC_CLK_HZ         100000000
`define FPMC_LONG_PRESS_MS  2000
`define FPMC_LONG_PRESS_CYC (`FPMC_CLK_HZ / 1000 * `FPMC_LONG_PRESS_MS)
`define FPMC_SHOW_NUM_MS    1000
`define FPMC_SHOW_NUM_CYC   (`FPMC_CLK_HZ / 1000 * `FPMC_SHOW_NUM_MS)
`define FPMC_IDLE_TO_S      120
// 120 s at 100 MHz; needs 34 bits
`define FPMC_IDLE_TO_CYC    36'h2cb417800
`define FPMC_BEEP_MS        100
`define FPMC_BEEP_CYC       (`FPMC_CLK_HZ / 1000 * `FPMC_BEEP_MS)
`define FPMC_DEBOUNCE_MS    10
`define FPMC_DEBOUNCE_CYC   (`FPMC_CLK_HZ / 1000 * `FPMC_DEBOUNCE_MS)
`define FPMC_FLASH_MS       250
`define FPMC_FLASH_CYC      (`FPMC_CLK_HZ / 1000 * `FPMC_FLASH_MS)
// AHB register offsets
`define FPMC_ADDR_CTRL      4'h0
`define FPMC_ADDR_STATUS    4'h1
`define FPMC_ADDR_SP1       4'h2
`define FPMC_ADDR_SP2       4'h3
`define FPMC_ADDR_MEAS      4'h4
// CTRL fields
`define FPMC_CTRL_SERIAL    0
`define FPMC_CTRL_LOCKOUT   1
`define FPMC_CTRL_RST       2'h0
// Baud codes 110..19200
`define FPMC_BAUD_RST       3'h6
`define FPMC_BAUD_MAX       3'h7
// Compensation
`define FPMC_COMP_NOM       8'h64
`define FPMC_COMP_MIN       8'h5a
`define FPMC_COMP_MAX       8'h6e
// Display kinds
`define FPMC_DISP_NORMAL    3'h0
`define FPMC_DISP_SEQNUM    3'h1
`define FPMC_DISP_VALUE     3'h2
`define FPMC_DISP_BAUD      3'h3
`define FPMC_DISP_SETPT     3'h4
`endif

// *** rtl/fpmc_debounce.v ***
// Synchroniser, debouncer and press edge detector for one button
`timescale 1ns/100ps
`include "fpmc_defs.vh"
module fpmc_debounce
#(
	parameter [31:0] DEBOUNCE_CYC = `FPMC_DEBOUNCE_CYC
)
(
	input  wire ref_clk,
	input  wire reset,
	input  wire rawIn,
	output reg  level_q,
	output reg  press_q
);
	reg        meta_q;
	reg        sync_q;
	reg [19:0] cnt_q;

	localparam [19:0] DB_LAST = DEBOUNCE_CYC[19:0] - 20'h1;

	always @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			meta_q  <= 1'b0;
			sync_q  <= 1'b0;
			cnt_q   <= 20'h0;
			level_q <= 1'b0;
			press_q <= 1'b0;
		end
		else
		begin
			meta_q  <= rawIn;
			sync_q  <= meta_q;
			press_q <= 1'b0;
			if (sync_q == level_q)
				cnt_q <= 20'h0;
			else if (cnt_q == DB_LAST)
			begin
				cnt_q   <= 20'h0;
				level_q <= sync_q;
				press_q <= sync_q;
			end
			else
				cnt_q <= cnt_q + 20'h1;
		end
	end
endmodule

// *** rtl/fpmc_alarm.v ***
// One oxygen alarm: setpoint arbitration and trip compare
`timescale 1ns/100ps
`include "fpmc_defs.vh"
module fpmc_alarm
#(
	parameter       TRIP_ABOVE = 0,
	parameter       ADJUSTABLE = 1,
	parameter [7:0] FIXED_SP   = 8'h32
)
(
	input  wire       ref_clk,
	input  wire       reset,
	input  wire [7:0] oxygen,
	input  wire [7:0] potValue,
	input  wire       tracking,
	input  wire       leaveSet,
	input  wire       localLock,
	input  wire       remoteWr,
	input  wire [7:0] remoteValue,
	output reg  [7:0] activeSp_q,
	output reg        alarm_q
);
	reg [7:0] manualSp_q;
	reg       remoteValid_q;

	always @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			manualSp_q    <= FIXED_SP;
			remoteValid_q <= 1'b0;
			activeSp_q    <= FIXED_SP;
			alarm_q       <= 1'b0;
		end
		else
		begin
			if (tracking && ADJUSTABLE != 0 && !localLock)
				manualSp_q <= potValue;
			if (remoteWr)
				remoteValid_q <= 1'b1;
			else if (leaveSet && !localLock)
				remoteValid_q <= 1'b0;
			if (remoteWr)
				activeSp_q <= remoteValue;
			else if (!remoteValid_q || (leaveSet && !localLock))
				activeSp_q <= manualSp_q;
			if (TRIP_ABOVE != 0)
				alarm_q <= oxygen > activeSp_q;
			else
				alarm_q <= oxygen < activeSp_q;
		end
	end
endmodule

// *** verif/fpmc_top_chk.sv ***
// Port assertions for the front-panel mode controller
`timescale 1ns/100ps
module fpmc_top_chk
(
	input wire       ref_clk,
	input wire       reset,
	input wire       compUp,
	input wire       compDown,
	input wire       hreadyout,
	input wire       hresp,
	input wire [2:0] dispKind_q,
	input wire       beep_q,
	input wire       outOfCal_q,
	input wire [2:0] baudSel_q,
	input wire       inNormal_q
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (reset);
	sequence numShown;
		(dispKind_q == 3'h1) [*8];
	endsequence
	sequence valueShown;
		dispKind_q == 3'h2 || dispKind_q == 3'h3;
	endsequence
	sequence beepPulse;
		beep_q [*3] ##[1:8] !beep_q;
	endsequence
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus not ready or not okay");
	a_beep_entry: assert property ($rose(beep_q) |-> !inNormal_q)
		else $error("beep outside diagnostic entry");
	a_beep_short: assert property ($rose(beep_q) |-> beepPulse)
		else $error("beep length wrong");
	a_num_first: assert property ($rose(dispKind_q == 3'h1) |->
		numShown ##[1:40] valueShown)
		else $error("sequence number not followed by value");
	a_normal_view: assert property (inNormal_q && $past(inNormal_q) |->
		dispKind_q == 3'h0)
		else $error("normal mode shows other display");
	a_cal_sticky: assert property (outOfCal_q |=> outOfCal_q)
		else $error("calibration alarm dropped");
	a_cal_cause: assert property ($rose(outOfCal_q) |-> $past(compUp) ||
		$past(compDown) || $past(compUp, 2) || $past(compDown, 2))
		else $error("calibration alarm without step");
	a_baud_step: assert property ($changed(baudSel_q) |-> !inNormal_q &&
		(baudSel_q == $past(baudSel_q) + 3'h1 || baudSel_q == $past(baudSel_q) - 3'h1))
		else $error("baud changed wrongly");
endmodule
bind fpmc_top fpmc_top_chk i_fpmc_top_chk
(
	.ref_clk, .reset, .compUp, .compDown, .hreadyout, .hresp, .dispKind_q, .beep_q,
	.outOfCal_q, .baudSel_q, .inNormal_q
);

// *** verif/fpmc_panel.sv ***
// Push-button panel model with contact bounce
`timescale 1ns/100ps
module fpmc_panel
(
	input  wire       ref_clk,
	output reg  [2:0] btnRaw
);
	localparam int DEBOUNCE = 8;
	initial btnRaw = 3'h0;
	// Bounce, hold past debounce, release and let it settle
	task automatic press(input int idx, input int hold);
		repeat (5)
		begin
			@(posedge ref_clk);
			btnRaw[idx] <= ~btnRaw[idx];
		end
		repeat (DEBOUNCE + hold) @(posedge ref_clk);
		btnRaw[idx] <= 1'b0;
		repeat (DEBOUNCE + 20) @(posedge ref_clk);
	endtask
endmodule

// *** verif/fpmc_top_tb_top.sv ***
// Self-checking bench for the front-panel mode controller
`timescale 1ns/100ps
`define CHK(n, e, g) \
	begin \
		checksDone++; \
		if ((g) !== (e)) \
		begin \
			nMismatch++; \
			$display("mismatch %s expected %0h seen %0h", n, e, g); \
		end \
	end
module fpmc_top_tb_top;
	localparam int IDLE = 300;
	logic        ref_clk = 1'b0;
	logic        reset = 1'b1;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic        compUp = 1'b0;
	logic        compDown = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] rd;
	logic [31:0] rng = 32'hb13ad122;
	logic [7:0]  oxygen = 8'h0;
	logic [7:0]  potValue1 = 8'h0;
	logic [7:0]  potValue2 = 8'h0;
	logic [7:0]  dv [5];
	wire  [31:0] hrdata;
	wire         hreadyout, hresp, beep_q, alarmLed1_q, alarmLed2_q, alarm1_q, alarm2_q;
	wire         outOfCal_q, inNormal_q;
	wire  [2:0]  dispKind_q, baudSel_q, btnRaw;
	wire  [7:0]  dispValue_q;
	int          nMismatch = 0;
	int          checksDone = 0;
	int          comp = 100;
	int          ooc = 0;
	int          baud = 6;
	always #5 ref_clk = ~ref_clk;
	fpmc_top #(.LONG_PRESS_CYC(50), .SHOW_NUM_CYC(20), .IDLE_TO_CYC(IDLE), .BEEP_CYC(5),
		.FLASH_CYC(4), .DEBOUNCE_CYC(8)) i_fpmc_top
	(
		.ref_clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .diagButton(btnRaw[0]),
		.setButton1(btnRaw[1]), .setButton2(btnRaw[2]), .oxygen, .potValue1, .potValue2,
		.diagValue1(dv[0]), .diagValue2(dv[1]), .diagValue3(dv[2]), .diagValue4(dv[3]),
		.diagValue5(dv[4]), .compUp, .compDown, .dispKind_q, .dispValue_q, .beep_q,
		.alarmLed1_q, .alarmLed2_q, .alarm1_q, .alarm2_q, .outOfCal_q, .baudSel_q, .inNormal_q
	);
	fpmc_panel i_fpmc_panel
	(
		.ref_clk, .btnRaw
	);
	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic st();
		ahb(1'b0, 32'h4, 32'h0);
	endtask
	task automatic endSim();
		$display("checks %0d mismatches %0d", checksDone, nMismatch);
		if (nMismatch == 0 && checksDone > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		// About twenty times the expected run
		#400000;
		nMismatch++;
		endSim();
	end
	initial
	begin
		int i;
		logic e;
		logic [7:0] sp;
		logic [7:0] ox;
		foreach (dv[k])
			dv[k] <= 8'(xs());
		repeat (16) @(posedge ref_clk);
		reset <= 1'b0;
		ahb(1'b0, 32'h0, 32'h0);
		`CHK("ctrl", 32'h0, rd)
		st();
		`CHK("comp", 8'h64, rd[23:16])
		ahb(1'b0, 32'h3c, 32'h0);
		`CHK("unmapped", 32'h0, rd)
		`CHK("baud", 3'h6, baudSel_q)
		$display("test reset done");
		for (i = 0; i < 44; i++)
		begin
			rd = xs();
			e = (i < 12) ? 1'b1 : (i < 36) ? 1'b0 : rd[0];
			compUp <= e;
			compDown <= ~e;
			@(posedge ref_clk);
			compUp <= 1'b0;
			compDown <= 1'b0;
			if (e ? comp == 110 : comp == 90)
				ooc = 1;
			else
				comp += e ? 1 : -1;
			st();
			`CHK("comp", comp, rd[23:16])
			`CHK("outofcal", ooc, outOfCal_q)
		end
		$display("test compensation done");
		for (i = 0; i < 8; i++)
		begin
			sp = 8'(16 + xs() % 200);
			ox = sp + 8'(xs() % 3) - 8'h1;
			oxygen <= ox;
			ahb(1'b1, i[0] ? 32'hc : 32'h8, {24'h0, sp});
			repeat (4) @(posedge ref_clk);
			`CHK("alarm", ox < sp, i[0] ? alarm2_q : alarm1_q)
			`CHK("led", ox < sp, i[0] ? alarmLed2_q : alarmLed1_q)
			ahb(1'b0, i[0] ? 32'hc : 32'h8, 32'h0);
			`CHK("setpoint", sp, rd[7:0])
		end
		$display("test serial setpoint done");
		ahb(1'b1, 32'h8, 32'h40);
		i_fpmc_panel.press(1, 10);
		`CHK("kind", 3'h4, dispKind_q)
		potValue1 <= 8'(xs());
		repeat (5) @(posedge ref_clk);
		`CHK("shown", potValue1, dispValue_q)
		sp = 8'h0;
		repeat (12)
		begin
			@(posedge ref_clk);
			sp[alarmLed1_q] = 1'b1;
		end
		`CHK("flash", 8'h3, sp)
		i_fpmc_panel.press(0, 10);
		`CHK("normal", 1'b1, inNormal_q)
		ahb(1'b0, 32'h8, 32'h0);
		`CHK("manual", potValue1, rd[7:0])
		ahb(1'b1, 32'h0, 32'h2);
		ahb(1'b1, 32'h8, 32'h20);
		i_fpmc_panel.press(1, 10);
		potValue1 <= 8'(xs());
		i_fpmc_panel.press(0, 10);
		ahb(1'b0, 32'h8, 32'h0);
		`CHK("locked", 8'h20, rd[7:0])
		reset <= 1'b1;
		repeat (2) @(posedge ref_clk);
		reset <= 1'b0;
		comp = 100;
		ooc = 0;
		ahb(1'b0, 32'h8, 32'h0);
		`CHK("volatile", 8'h32, rd[7:0])
		ahb(1'b1, 32'h0, 32'h1);
		$display("test setpoint mode done");
		i_fpmc_panel.press(0, 80);
		`CHK("diag", 1'b0, inNormal_q)
		for (i = 1; i <= 7; i++)
		begin
			if (i > 1)
				i_fpmc_panel.press(0, 10);
			st();
			`CHK("seq", i, rd[10:8])
			if (i < 6)
				`CHK("value", dv[i - 1], dispValue_q)
			if (i == 6)
			begin
				`CHK("factor", comp, dispValue_q)
				repeat (IDLE + 100) @(posedge ref_clk);
				`CHK("idle", 1'b0, inNormal_q)
			end
		end
		`CHK("baudview", 3'h3, dispKind_q)
		for (i = 0; i < 3; i++)
		begin
			i_fpmc_panel.press(i < 2 ? 1 : 2, 10);
			baud = (i < 2) ? ((baud < 7) ? baud + 1 : 7) : ((baud > 0) ? baud - 1 : 0);
			`CHK("baud", baud, baudSel_q)
			`CHK("stay", 1'b0, inNormal_q)
		end
		i_fpmc_panel.press(0, 10);
		st();
		`CHK("seq", 3'h1, rd[10:8])
		i_fpmc_panel.press(2, 10);
		`CHK("exit", 1'b1, inNormal_q)
		`CHK("normview", oxygen, dispValue_q)
		i_fpmc_panel.press(0, 80);
		repeat (IDLE + 100) @(posedge ref_clk);
		`CHK("timeout", 1'b1, inNormal_q)
		$display("test diagnostic mode done");
		endSim();
	end
endmodule
